// ### src/ipd_cfg.svh
// Constants for the idle and power-down controller
`ifndef IPD_CFG_SVH
`define IPD_CFG_SVH
`define IPD_PWR_CTRL_ADDR 8'h87
`define IPD_BIT_IDLE 0
`define IPD_BIT_PDOWN 1
`define IPD_PWR_CTRL_RESET 8'h00
`define IPD_RESET_VECTOR 16'h0000
`define IPD_OSC_SETTLE_NS 1000
`define IPD_CLK_NS 10
`define IPD_OSC_SETTLE_CYC ((`IPD_OSC_SETTLE_NS + `IPD_CLK_NS - 1) / `IPD_CLK_NS)
`define IPD_CNT_W 8
`endif

// ### src/ipd_pkg.sv
// Types for the idle and power-down controller
package ipd_pkg;
  typedef enum logic [1:0]
  {
    IPD_RUN = 2'b00,
    IPD_IDLE = 2'b01,
    IPD_PDOWN = 2'b11,
    IPD_WAKE = 2'b10
  } ipd_state_t;
endpackage : ipd_pkg

// ### src/ipd_wake_if.sv
// Wake request bundle between the synchroniser and the mode controller
`timescale 1ns/1ps
interface ipd_wake_if;
  logic [1:0] ext_level;
  logic [1:0] ext_fall;
  modport src (output ext_level, output ext_fall);
  modport dst (input ext_level, input ext_fall);
endinterface : ipd_wake_if

// ### src/ipd_pin_sync.sv
// Two-stage synchroniser and falling edge finder for the wake pins
`timescale 1ns/1ps
module ipd_pin_sync
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] ext_int_pin_n,
  ipd_wake_if.src wake
);
  import ipd_pkg::*;
  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] prev;
  logic [1:0] next_meta;
  logic [1:0] next_sync;
  logic [1:0] next_prev;

  // Next values; only the second stage feeds the edge finder
  always_comb
  begin
    next_meta = ext_int_pin_n;
    next_sync = meta;
    next_prev = sync;
  end

  // Pins idle high, so reset to one to avoid a false edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 2'h3;
      sync <= 2'h3;
      prev <= 2'h3;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign wake.ext_level = ~sync;
  assign wake.ext_fall = prev & ~sync;
endmodule : ipd_pin_sync

// ### src/ipd_ctrl.sv
// Idle and power-down mode controller of the processor core
// What this block does
// RQ1 - Writing one to bit 0 of power control at 87h enters Idle.
// RQ2 - The write setting idle is the last instruction before Idle.
// RQ3 - Idle gates only the processor clock; peripheral clocks keep running.
// RQ4 - Idle holds address latch and program store strobes high.
// RQ5 - Any enabled interrupt wakes Idle, clears idle bit, runs handler.
// RQ6 - External, power-on or watchdog reset ends Idle, restarts at 0000h.
// RQ7 - Writing one to bit 1 of power control at 87h enters Power-Down.
// RQ8 - Power-Down stops every clock, peripherals and watchdog included.
// RQ9 - Power-Down drives address latch and program store strobes low.
// RQ10 - External or power-on reset ends Power-Down, restarts from 0000h.
// RQ11 - Watchdog reset cannot end Power-Down since its clock stops.
// RQ12 - Enabled low-level or falling-edge external interrupt wakes Power-Down.
// RQ13 - After external interrupt wake, handler runs then program resumes.
// RQ14 - Idle and power-down set together count as Power-Down.
// RQ15 - Core clock stays gated until restarted oscillator is stable; a reset out of Power-Down enables it at once, with no settle wait.
`timescale 1ns/1ps
`include "ipd_cfg.svh"
module ipd_ctrl
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic irq_pending,
  input wire logic global_irq_enable,
  input wire logic [1:0] ext_irq_enable,
  input wire logic [1:0] ext_irq_edge,
  input wire logic [1:0] ext_int_pin_n,
  input wire logic ext_reset,
  input wire logic wdt_reset,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic core_reset,
  output logic [15:0] pc_load_value,
  output logic addr_latch_strobe,
  output logic program_store_strobe,
  output logic ext_bus_hold,
  output ipd_pkg::ipd_state_t mode
);
  import ipd_pkg::*;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  ipd_wake_if wake_bus ();
  ipd_pin_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ext_int_pin_n(ext_int_pin_n),
    .wake(wake_bus)
  );

  // ****************************************************************
  // Mode state and power control register
  // ****************************************************************
  ipd_state_t state;
  ipd_state_t next_state;
  logic [7:0] power_control_reg;
  logic [7:0] next_pwr_ctrl;
  logic [`IPD_CNT_W-1:0] settle;
  logic [`IPD_CNT_W-1:0] next_settle;
  logic [7:0] next_rdata;
  logic pwr_ctrl_wr;
  logic ext_wake;
  logic any_reset;
  logic [1:0] ext_hit;

  assign pwr_ctrl_wr = sfr_wr && (sfr_addr == `IPD_PWR_CTRL_ADDR);
  // Level or edge detection per pin, gated by both enables
  assign ext_hit = (ext_irq_edge & wake_bus.ext_fall)
                 | (~ext_irq_edge & wake_bus.ext_level);
  assign ext_wake = global_irq_enable && |(ext_hit & ext_irq_enable); // [RQ12]
  // Watchdog is ignored in Power-Down: its clock is stopped there
  assign any_reset = ext_reset
                   || (wdt_reset && state != IPD_PDOWN); // [RQ6] [RQ11]

  // Next-state and register computation
  always_comb
  begin
    next_state = state;
    next_pwr_ctrl = power_control_reg;
    next_settle = settle;
    next_rdata = 8'h00;
    if (sfr_rd && sfr_addr == `IPD_PWR_CTRL_ADDR)
      next_rdata = power_control_reg;
    if (any_reset)
    begin
      // Clock already running in Idle, so no settle delay
      next_state = IPD_RUN; // [RQ6] [RQ10]
      next_pwr_ctrl = `IPD_PWR_CTRL_RESET;
    end
    else
    begin
      case (state)
        IPD_RUN:
        begin
          if (pwr_ctrl_wr)
          begin
            next_pwr_ctrl = sfr_wdata;
            if (sfr_wdata[`IPD_BIT_PDOWN])
              next_state = IPD_PDOWN; // [RQ7] [RQ14]
            else if (sfr_wdata[`IPD_BIT_IDLE])
              next_state = IPD_IDLE; // [RQ1] [RQ2]
          end
        end
        IPD_IDLE:
        begin
          if (irq_pending)
          begin
            next_pwr_ctrl[`IPD_BIT_IDLE] = 1'b0; // [RQ5]
            next_state = IPD_RUN;
          end
        end
        IPD_PDOWN:
        begin
          if (ext_wake)
          begin
            next_settle = `IPD_CNT_W'(`IPD_OSC_SETTLE_CYC); // [RQ15]
            next_state = IPD_WAKE;
          end
        end
        IPD_WAKE:
        begin
          if (settle == '0)
          begin
            next_pwr_ctrl[`IPD_BIT_PDOWN] = 1'b0; // [RQ13]
            next_state = IPD_RUN;
          end
          else
            next_settle = settle - 1'b1;
        end
        default: next_state = IPD_RUN;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= IPD_RUN;
      power_control_reg <= `IPD_PWR_CTRL_RESET;
      settle <= '0;
      sfr_rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
      power_control_reg <= next_pwr_ctrl;
      settle <= next_settle;
      sfr_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Clock gates, strobes and reset vector
  // ****************************************************************
  logic next_cpu_en;
  logic next_per_en;
  logic next_osc;
  logic next_ale;
  logic next_pss;
  logic next_hold;
  logic next_core_rst;

  // Outputs decoded from the next state so they align with it
  always_comb
  begin
    next_cpu_en = (next_state == IPD_RUN); // [RQ3] [RQ15]
    next_per_en = (next_state != IPD_PDOWN)
               && (next_state != IPD_WAKE); // [RQ8]
    next_osc = (next_state != IPD_PDOWN); // [RQ8]
    next_ale = (next_state != IPD_PDOWN)
            && (next_state != IPD_WAKE); // [RQ4] [RQ9]
    next_pss = next_ale; // [RQ4] [RQ9]
    // Ports keep their latches while the core is stopped
    next_hold = (next_state != IPD_RUN);
    next_core_rst = any_reset; // [RQ6] [RQ10]
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b1;
      osc_run <= 1'b1;
      addr_latch_strobe <= 1'b1;
      program_store_strobe <= 1'b1;
      ext_bus_hold <= 1'b0;
      core_reset <= 1'b1;
      mode <= IPD_RUN;
      pc_load_value <= `IPD_RESET_VECTOR;
    end
    else
    begin
      cpu_clk_en <= next_cpu_en;
      periph_clk_en <= next_per_en;
      osc_run <= next_osc;
      addr_latch_strobe <= next_ale;
      program_store_strobe <= next_pss;
      ext_bus_hold <= next_hold;
      core_reset <= next_core_rst;
      mode <= next_state;
      pc_load_value <= `IPD_RESET_VECTOR;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_pd_entry;
    state == IPD_RUN && pwr_ctrl_wr && sfr_wdata[`IPD_BIT_PDOWN];
  endsequence

  a_idle_entry: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ1]
    state == IPD_RUN && pwr_ctrl_wr && !any_reset && sfr_wdata[`IPD_BIT_IDLE]
    && !sfr_wdata[`IPD_BIT_PDOWN] |=> state == IPD_IDLE && !cpu_clk_en)
    else $error("idle not entered");
  a_pd_entry: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ14]
    s_pd_entry and !any_reset |=> state == IPD_PDOWN && !osc_run)
    else $error("power-down not entered");
  a_idle_strobes: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ4]
    state == IPD_IDLE |-> addr_latch_strobe && program_store_strobe
    && periph_clk_en)
    else $error("idle strobes wrong");
  a_pd_strobes: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ9]
    state == IPD_PDOWN |-> !addr_latch_strobe && !program_store_strobe
    && !periph_clk_en)
    else $error("power-down strobes wrong");
  a_idle_wake: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ5]
    state == IPD_IDLE && irq_pending && !any_reset
    |=> state == IPD_RUN && !power_control_reg[`IPD_BIT_IDLE] && cpu_clk_en)
    else $error("idle wake failed");
  a_wdt_pd: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ11]
    state == IPD_PDOWN && wdt_reset && !ext_reset && !ext_wake
    |=> state == IPD_PDOWN)
    else $error("watchdog left power-down");
  a_reset_exit: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ10]
    ext_reset |=> state == IPD_RUN && core_reset
    && power_control_reg == `IPD_PWR_CTRL_RESET)
    else $error("reset did not exit");
  a_settle_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
    state == IPD_PDOWN && ext_wake && !any_reset
    |=> !cpu_clk_en [*8])
    else $error("core released early");
  a_wake_done: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ13]
    state == IPD_PDOWN && ext_wake && !any_reset
    |-> ##[1:110] state == IPD_RUN || any_reset)
    else $error("power-down wake too slow");
endmodule : ipd_ctrl

// ### verification/ipd_irq_model.sv
// Interrupt controller model facing the mode controller
`timescale 1ns/1ps
module ipd_irq_model
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic global_irq_enable,
  output logic irq_pending
);
  // Pending only while globally enabled; masked sources never reach it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_pending <= 1'b0;
    else
      irq_pending <= irq_req & global_irq_enable;
  end
endmodule : ipd_irq_model

// ### verification/testbench.sv
// Self-checking bench for the idle and power-down controller
`timescale 1ns/1ps
`include "ipd_cfg.svh"
module testbench import ipd_pkg::*;;
  logic clk_sys = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic irq_req = 0, irq_pending, gie = 0, ext_reset = 0, wdt_reset = 0;
  logic [1:0] ext_en = 0, ext_edge = 0, pin_n = 2'b11;
  logic cpu, per, osc, core_rst, als, pss, hold;
  logic [15:0] pc_val;
  ipd_state_t mode;
  int errors = 0, comparisons = 0, cyc = 0;
  // ******************************************
  // Clock, partner and design
  // ******************************************
  always #5 clk_sys = ~clk_sys;
  ipd_irq_model irq_u (.clk_sys(clk_sys), .rst_n(rst_n), .irq_req(irq_req),
    .global_irq_enable(gie), .irq_pending(irq_pending));
  ipd_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq_pending(irq_pending),
    .global_irq_enable(gie), .ext_irq_enable(ext_en),
    .ext_irq_edge(ext_edge), .ext_int_pin_n(pin_n), .ext_reset(ext_reset),
    .wdt_reset(wdt_reset), .cpu_clk_en(cpu), .periph_clk_en(per),
    .osc_run(osc), .core_reset(core_rst), .pc_load_value(pc_val),
    .addr_latch_strobe(als), .program_store_strobe(pss),
    .ext_bus_hold(hold), .mode(mode));
  // ******************************************
  // Shared tasks
  // ******************************************
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // One-cycle strobes, issued just after the edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr = 1; sfr_addr = a; sfr_wdata = d;
    @(posedge clk_sys) #1;
    sfr_wr = 0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    sfr_rd = 1; sfr_addr = a;
    @(posedge clk_sys) #1;
    sfr_rd = 0;
    d = sfr_rdata;
  endtask : rd
  // Bounded wait for a mode; returns the cycles taken
  task wait_mode(input ipd_state_t m, output int n);
    n = 0;
    while (mode !== m && n < 300)
    begin
      @(posedge clk_sys) #1;
      n++;
    end
    chk("mode", mode, m);
  endtask : wait_mode
  task outs(input logic [6:0] e);
    chk("outs", {cpu, per, osc, als, pss, hold, core_rst}, e);
  endtask : outs
  // ******************************************
  // Scenarios
  // ******************************************
  task t_idle;
    logic [7:0] d;
    int n;
    wr(8'h55, 8'h01);
    chk("unmapped", mode, IPD_RUN);
    rd(8'h55, d); chk("rd_unmap", d, 8'h00);
    wr(`IPD_PWR_CTRL_ADDR, 8'h01);
    chk("mode_idle", mode, IPD_IDLE);
    outs(7'b0111110);
    rd(`IPD_PWR_CTRL_ADDR, d); chk("pc_idle", d, 8'h01);
    gie = 1; irq_req = 1;
    wait_mode(IPD_RUN, n);
    irq_req = 0;
    chk("cpu_on", cpu, 1'b1);
    rd(`IPD_PWR_CTRL_ADDR, d); chk("idle_clr", d, 8'h00);
    wr(`IPD_PWR_CTRL_ADDR, 8'h01);
    wdt_reset = 1;
    @(posedge clk_sys) #1;
    wdt_reset = 0;
    chk("wdt_idle", mode, IPD_RUN);
    chk("vec", pc_val, `IPD_RESET_VECTOR);
  endtask : t_idle
  task t_pdown(input logic edge_sel, input int p);
    logic [7:0] d;
    int n;
    ext_edge[p] = edge_sel; ext_en = 0;
    wr(`IPD_PWR_CTRL_ADDR, 8'h03);
    chk("mode_pd", mode, IPD_PDOWN);
    outs(7'b0000010);
    wdt_reset = 1; irq_req = 1;
    repeat (3) @(posedge clk_sys) #1;
    wdt_reset = 0; irq_req = 0;
    chk("wdt_pd", mode, IPD_PDOWN);
    pin_n[p] = 0;
    repeat (5) @(posedge clk_sys) #1;
    chk("masked", mode, IPD_PDOWN);
    // Let the synchroniser clear before enabling, or a level wakes at once
    pin_n[p] = 1;
    repeat (3) @(posedge clk_sys) #1;
    ext_en[p] = 1; pin_n[p] = 0;
    wait_mode(IPD_WAKE, n);
    chk("wake_t", n, 3);
    outs(7'b0010010);
    wait_mode(IPD_RUN, n);
    chk("settle", n, `IPD_OSC_SETTLE_CYC + 1);
    outs(7'b1111100);
    pin_n[p] = 1;
    // Wake clears only the power-down bit; idle bit of 03 stays
    rd(`IPD_PWR_CTRL_ADDR, d); chk("pd_clr", d, 8'h01);
  endtask : t_pdown
  task t_reset_pd;
    wr(`IPD_PWR_CTRL_ADDR, 8'h02);
    ext_reset = 1;
    @(posedge clk_sys) #1;
    ext_reset = 0;
    chk("rst_pd", mode, IPD_RUN);
    chk("osc_on", osc, 1'b1);
    chk("core_rst", core_rst, 1'b1);
    chk("vec_pd", pc_val, `IPD_RESET_VECTOR);
  endtask : t_reset_pd
  // ******************************************
  // Main sequence and hang guard
  // ******************************************
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1;
    repeat (2) @(posedge clk_sys) #1;
    outs(7'b1111100);
    chk("mode_rst", mode, IPD_RUN);
    t_idle;
    t_pdown(1'b1, 0);
    t_pdown(1'b0, 1);
    t_reset_pd;
    test_done;
  end
endmodule : testbench
